// File: hdl/rrpc_defs.svh
// Constants of the remote relay pairing controller
// Assumes 100 MHz pclk; times are in ms and counted on a 1 ms tick
`ifndef RRPC_DEFS_SVH
`define RRPC_DEFS_SVH

`define RRPC_ADDR_CTRL    12'h000
`define RRPC_ADDR_STATUS  12'h004
`define RRPC_ADDR_CODE    12'h008
`define RRPC_CTRL_RST     2'h0
`define RRPC_CTRL_MAINS   0
`define RRPC_CTRL_TWO     1
`define RRPC_STS_FSM      0
`define RRPC_STS_SEL      4
`define RRPC_STS_PCN      8
`define RRPC_STS_CNT      12
`define RRPC_STS_RLY      20

`define RRPC_ENTRIES      40
`define RRPC_CNT_MAX      6'd40
`define RRPC_CODE_W       28

`define RRPC_CLK_NS       10
`define RRPC_MS_NS        1000000
`define RRPC_MS_CYC       (`RRPC_MS_NS / `RRPC_CLK_NS)

`define RRPC_BOOT_MS      14'd10000
`define RRPC_ERASE_MS     14'd10000
`define RRPC_HOLD_LED_MS  14'd1000
`define RRPC_PRESS_MS     14'd30
`define RRPC_SETTLE_MS    14'd5000
`define RRPC_RETURN_MS    14'd10000
`define RRPC_PC_MIN_MS    14'd300
`define RRPC_PC_MAX_MS    14'd2000
`define RRPC_MOM_HOLD_MS  8'd250
`define RRPC_FLASH_MS     8'd250
`define RRPC_BUZZ_MS      8'd200
`define RRPC_CLICK_MS     8'd50
`define RRPC_CLICK_PH     8'd200
`define RRPC_DONE_PH      8'd6
`define RRPC_PC_LEARN1    4'd4
`define RRPC_PC_LEARN2    4'd6
`define RRPC_PC_ERASE     4'd10

`endif

// File: hdl/rrpc_pair_mem.sv
// Pairing store: forty code-to-relay entries, lookup, add, erase all
// Assumes one clock; register file stands in for nonvolatile storage
`timescale 1ns/10ps
`include "rrpc_defs.svh"
module rrpc_pair_mem (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  pclken,
  input  wire rrpc_pkg::rrpc_rx_t    look,
  input  wire logic                  store,
  input  wire rrpc_pkg::rrpc_entry_t store_ent,
  input  wire logic                  erase,
  output rrpc_pkg::rrpc_match_t      match,
  output logic [5:0]                 count
);
  import rrpc_pkg::*;

  typedef struct packed {
    rrpc_entry_t [`RRPC_ENTRIES-1:0] ent;
    rrpc_match_t                     m;
    logic [5:0]                      cnt;
  } rrpc_mem_st_t;

  rrpc_mem_st_t st;
  rrpc_mem_st_t next_st;

  // One code may map to several relays, so hits form a mask
  function automatic logic [3:0] hits(rrpc_mem_st_t s,
                                      logic [`RRPC_CODE_W-1:0] c);
    logic [3:0] h;
    h = 4'h0;
    for (int i = 0; i < `RRPC_ENTRIES; i++)
      if (s.ent[i].valid && s.ent[i].code == c)
        h[s.ent[i].relay] = 1'b1;
    return h;
  endfunction : hits

  always_comb
  begin
    logic       done;
    logic [3:0] sh;
    done = 1'b0;
    sh = hits(st, store_ent.code);
    next_st = st;
    next_st.m.valid = look.valid;
    next_st.m.mask = look.valid ? hits(st, look.code) : 4'h0;
    if (erase)
    begin
      for (int i = 0; i < `RRPC_ENTRIES; i++)
        next_st.ent[i].valid = 1'b0;
      next_st.cnt = 6'd0;
    end
    else if (store && !sh[store_ent.relay]
             && st.cnt < `RRPC_CNT_MAX)
    begin
      for (int i = 0; i < `RRPC_ENTRIES; i++)
        if (!done && !st.ent[i].valid)
        begin
          next_st.ent[i] = store_ent;
          next_st.ent[i].valid = 1'b1;
          done = 1'b1;
        end
      next_st.cnt = st.cnt + 6'd1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= '0;
    else if (pclken)
      st <= next_st;
  end

  assign match = st.m;
  assign count = st.cnt;

  default clocking mcb @(posedge pclk iff pclken);
  endclocking
  default disable iff (!presetn);

  sequence s_stored;
    store && !erase && count < `RRPC_CNT_MAX;
  endsequence

  a_count_bound: assert property (count <= `RRPC_CNT_MAX)
    else $error("pairing count above capacity");
  a_erase_empties: assert property (erase |=> count == 6'd0)
    else $error("erase left entries");
  a_stored_hits: assert property (
    s_stored ##1 (look.valid && look.code == $past(store_ent.code))
    |=> match.mask[$past(store_ent.relay, 2)])
    else $error("stored pairing not found");
endmodule : rrpc_pair_mem

// File: hdl/rrpc_pkg.sv
// Types shared by the pairing controller and its pairing store
// Assumes rrpc_defs.svh is on the include path
`include "rrpc_defs.svh"
package rrpc_pkg;
  typedef enum logic [2:0] {
    RRPC_BOOT, RRPC_NORMAL, RRPC_SELECT, RRPC_CAPT, RRPC_DONE, RRPC_CLICK
  } rrpc_state_t;
  typedef struct packed {
    logic                    valid;
    logic [`RRPC_CODE_W-1:0] code;
  } rrpc_rx_t;
  typedef struct packed {
    logic                    valid;
    logic [`RRPC_CODE_W-1:0] code;
    logic [1:0]              relay;
  } rrpc_entry_t;
  typedef struct packed {
    logic       valid;
    logic [3:0] mask;
  } rrpc_match_t;
endpackage : rrpc_pkg

// File: hdl/rrpc_top.sv
// Remote relay pairing controller: learn, erase, relay drive, APB regs
// Assumes rx frames are decoded on pclk; pins are asynchronous
//
// How it works
// - Store at most forty button pairings
// - Match by transmitter code, any relay target
// - First short press selects relay one, one flash
// - Later presses after flashing advance the relay
// - First code reception lights learn LED steadily
// - Same code again stores pairing, LED flashes
// - Paired code afterwards operates its relay
// - Ten second hold erases all, LED off
// - Erase always clears whole memory
// - Four-relay jumpers choose momentary or latching
// - Normal one cycle after reset: ctrl resets non-mains, so the ten-second boot wait never runs
// - Four power cycles: single buzz, learn one
// - Six power cycles: double buzz, learn two
// - Power-cycle learn answers first code and same code again with buzz
// - Power-cycle learn returns normal ten seconds later
// - Ten power cycles: click ten seconds, erase
// - Mains relays chatter as audible feedback
// - Two-relay jumper per relay, open momentary
// - Relay operates within 100 ms
// - Momentary relay releases within 300 ms
// - Drive high energises relay, common to NO
`timescale 1ns/10ps
`include "rrpc_defs.svh"
module rrpc_top #(
  parameter int MS_CYCLES = `RRPC_MS_CYC
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               pclken,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire rrpc_pkg::rrpc_rx_t rx,
  input  wire logic               learn_pushbutton,
  input  wire logic               mode_jumper_a,
  input  wire logic               mode_jumper_b,
  input  wire logic               supply_sense,
  output logic [3:0]              relay_outputs_all,
  output logic                    learn_led,
  output logic                    buzzer
);
  import rrpc_pkg::*;

  typedef struct packed {
    logic [3:0]              s1;
    logic [3:0]              s2;
    logic                    btn_q;
    logic                    sup_q;
    logic [1:0]              ctrl;
    logic [31:0]             prdata;
    logic                    pslverr;
    logic [19:0]             pre;
    logic                    tick;
    rrpc_state_t             fsm;
    logic [1:0]              sel;
    logic [13:0]             tmr;
    logic [13:0]             hold;
    logic [13:0]             pc_t;
    logic [3:0]              pc_n;
    logic [7:0]              rg;
    logic [`RRPC_CODE_W-1:0] cap;
    logic [`RRPC_CODE_W-1:0] last;
    logic [7:0]              fb_n;
    logic [7:0]              fb_t;
    logic [7:0]              fb_half;
    logic [3:0]              rly;
    logic [3:0][7:0]         rt;
    logic [3:0]              act;
    logic                    led;
    logic                    buz;
    logic                    store;
    logic                    erase;
  } rrpc_top_st_t;

  rrpc_top_st_t st;
  rrpc_top_st_t next_st;
  rrpc_match_t  hit_m;
  rrpc_entry_t  sent;
  logic [5:0]   count;
  logic         btn;
  logic         sup;
  logic         mains;
  logic         two;
  logic [3:0]   mom;
  logic [3:0]   en;
  logic [3:0]   hit;
  logic [1:0]   sel_nx;
  logic         fb_busy;
  logic         fb_on;
  logic         fb_state;
  logic         press;
  logic         new_press;
  logic         eval;

  // Feedback pattern: ph phases of half ms each, starting lit
  function automatic rrpc_top_st_t fb_go(rrpc_top_st_t s,
                                         logic [7:0] ph,
                                         logic [7:0] half);
    s.fb_n = ph;
    s.fb_t = half;
    s.fb_half = half;
    return s;
  endfunction : fb_go

  // Relay n+1 is told by n+1 pulses
  function automatic logic [7:0] ph_of(logic [1:0] s);
    return {4'd0, {1'b0, s} + 3'd1, 1'b0};
  endfunction : ph_of

  function automatic logic [3:0] mom_map(logic tw, logic ja, logic jb);
    if (tw)
      return {2'b00, !jb, !ja};
    case ({ja, jb})
      2'b11:   return 4'hf;
      2'b10:   return 4'h3;
      2'b01:   return 4'h1;
      default: return 4'h0;
    endcase
  endfunction : mom_map

  assign btn = st.s2[0];
  assign sup = st.s2[3];
  assign mains = st.ctrl[`RRPC_CTRL_MAINS];
  assign two = st.ctrl[`RRPC_CTRL_TWO];
  assign mom = mom_map(two, st.s2[1], st.s2[2]);
  assign en = two ? 4'h3 : 4'hf;
  assign hit = hit_m.valid ? (hit_m.mask & en) : 4'h0;
  assign sel_nx = (two && st.sel == 2'd1) ? 2'd0 : st.sel + 2'd1;
  assign fb_busy = st.fb_n != 8'd0;
  assign fb_on = fb_busy && !st.fb_n[0];
  assign fb_state = st.fsm inside {RRPC_SELECT, RRPC_CAPT, RRPC_DONE,
                                   RRPC_CLICK};
  // Short press counts on release; long holds belong to erase
  assign press = !mains && !btn && st.btn_q
                 && st.hold >= `RRPC_PRESS_MS && st.hold < `RRPC_ERASE_MS;
  // Frames repeat while a button is held; a gap marks a new press
  assign new_press = rx.valid && st.rg == 8'd0;
  assign eval = mains && st.fsm == RRPC_NORMAL && sup && st.tick
                && st.pc_n != 4'd0 && st.pc_t == `RRPC_SETTLE_MS - 14'd1;
  assign sent = {1'b1, st.cap, st.sel};

  rrpc_pair_mem u_mem (
    .pclk      (pclk),
    .presetn   (presetn),
    .pclken    (pclken),
    .look      (rx),
    .store     (st.store),
    .store_ent (sent),
    .erase     (st.erase),
    .match     (hit_m),
    .count     (count)
  );

  always_comb
  begin
    next_st = st;
    next_st.store = 1'b0;
    next_st.erase = 1'b0;
    next_st.tick = st.pre == 20'(MS_CYCLES - 1);
    next_st.pre = next_st.tick ? 20'd0 : st.pre + 20'd1;
    next_st.s1 = {supply_sense, mode_jumper_b, mode_jumper_a,
                  learn_pushbutton};
    next_st.s2 = st.s1;
    next_st.btn_q = btn;
    next_st.sup_q = sup;

    // Read data is captured in the setup cycle for a zero-wait access
    if (psel && !penable)
    begin
      next_st.prdata = 32'h0000_0000;
      next_st.pslverr = 1'b0;
      if (paddr == `RRPC_ADDR_CTRL)
        next_st.prdata[1:0] = st.ctrl;
      else if (paddr == `RRPC_ADDR_STATUS)
      begin
        next_st.prdata[`RRPC_STS_FSM +: 3] = st.fsm;
        next_st.prdata[`RRPC_STS_SEL +: 2] = st.sel;
        next_st.prdata[`RRPC_STS_PCN +: 4] = st.pc_n;
        next_st.prdata[`RRPC_STS_CNT +: 6] = count;
        next_st.prdata[`RRPC_STS_RLY +: 4] = st.rly;
      end
      else if (paddr == `RRPC_ADDR_CODE)
        next_st.prdata[`RRPC_CODE_W-1:0] = st.last;
      else
        next_st.pslverr = 1'b1;
    end
    if (psel && penable && pwrite && paddr == `RRPC_ADDR_CTRL)
      next_st.ctrl = pwdata[1:0];

    if (rx.valid)
    begin
      next_st.last = rx.code;
      next_st.rg = `RRPC_MOM_HOLD_MS;
    end
    else if (st.tick && st.rg != 8'd0)
      next_st.rg = st.rg - 8'd1;

    if (st.tick && fb_busy)
    begin
      if (st.fb_t <= 8'd1)
      begin
        next_st.fb_n = st.fb_n - 8'd1;
        next_st.fb_t = st.fb_half;
      end
      else
        next_st.fb_t = st.fb_t - 8'd1;
    end
    if (st.tick && st.tmr != 14'd0)
      next_st.tmr = st.tmr - 14'd1;

    if (!btn)
      next_st.hold = 14'd0;
    else if (st.tick && st.hold != `RRPC_ERASE_MS)
      next_st.hold = st.hold + 14'd1;

    // Power cycles count only from normal operation
    if (mains && st.fsm == RRPC_NORMAL)
    begin
      if (st.tick && st.pc_t < `RRPC_SETTLE_MS)
        next_st.pc_t = st.pc_t + 14'd1;
      if (sup != st.sup_q)
      begin
        next_st.pc_t = 14'd0;
        if (sup)
          next_st.pc_n = (st.pc_t >= `RRPC_PC_MIN_MS
                          && st.pc_t <= `RRPC_PC_MAX_MS
                          && st.pc_n != 4'hf)
                         ? st.pc_n + 4'd1 : 4'd0;
        else if (st.pc_t > `RRPC_PC_MAX_MS)
          next_st.pc_n = 4'd0;
      end
      else if (eval)
        next_st.pc_n = 4'd0;
    end
    else
    begin
      next_st.pc_n = 4'd0;
      next_st.pc_t = 14'd0;
    end

    case (st.fsm)
      RRPC_BOOT:
        if (!mains || st.tmr == 14'd0)
          next_st.fsm = RRPC_NORMAL;
      RRPC_NORMAL:
        if (press)
        begin
          next_st.fsm = RRPC_SELECT;
          next_st.sel = 2'd0;
          next_st = fb_go(next_st, ph_of(2'd0), `RRPC_FLASH_MS);
        end
        else if (eval && st.pc_n == `RRPC_PC_LEARN1)
        begin
          next_st.fsm = RRPC_SELECT;
          next_st.sel = 2'd0;
          next_st = fb_go(next_st, ph_of(2'd0), `RRPC_BUZZ_MS);
        end
        else if (eval && st.pc_n == `RRPC_PC_LEARN2)
        begin
          next_st.fsm = RRPC_SELECT;
          next_st.sel = 2'd1;
          next_st = fb_go(next_st, ph_of(2'd1), `RRPC_BUZZ_MS);
        end
        else if (eval && st.pc_n == `RRPC_PC_ERASE)
        begin
          next_st.fsm = RRPC_CLICK;
          next_st.sel = 2'd0;
          next_st = fb_go(next_st, `RRPC_CLICK_PH, `RRPC_CLICK_MS);
        end
      RRPC_SELECT:
        if (press && !fb_busy)
        begin
          next_st.sel = sel_nx;
          next_st = fb_go(next_st, ph_of(sel_nx), `RRPC_FLASH_MS);
        end
        else if (new_press && !fb_busy)
        begin
          next_st.cap = rx.code;
          next_st.fsm = RRPC_CAPT;
          if (mains)
            next_st = fb_go(next_st, ph_of(st.sel), `RRPC_BUZZ_MS);
        end
      RRPC_CAPT:
        if (new_press && !fb_busy)
        begin
          if (rx.code == st.cap)
          begin
            next_st.store = 1'b1;
            next_st.fsm = RRPC_DONE;
            next_st.tmr = mains ? `RRPC_RETURN_MS : 14'd0;
            next_st = mains
              ? fb_go(next_st, ph_of(st.sel), `RRPC_BUZZ_MS)
              : fb_go(next_st, `RRPC_DONE_PH, `RRPC_FLASH_MS);
          end
          else
            next_st.cap = rx.code;
        end
      RRPC_DONE:
        if (!fb_busy && st.tmr == 14'd0)
          next_st.fsm = RRPC_NORMAL;
      RRPC_CLICK:
        if (!fb_busy)
        begin
          next_st.erase = 1'b1;
          next_st.fsm = RRPC_NORMAL;
        end
      default:
        next_st.fsm = RRPC_NORMAL;
    endcase

    // Long hold wins over any learn step in progress
    if (!mains && btn && st.tick && st.hold == `RRPC_ERASE_MS - 14'd1)
    begin
      next_st.erase = 1'b1;
      next_st.fsm = RRPC_NORMAL;
      next_st.fb_n = 8'd0;
    end

    for (int i = 0; i < 4; i++)
    begin
      if (st.tick && st.rt[i] != 8'd0)
      begin
        next_st.rt[i] = st.rt[i] - 8'd1;
        if (st.rt[i] == 8'd1)
          next_st.act[i] = 1'b0;
      end
      if (st.fsm == RRPC_NORMAL && hit[i])
      begin
        next_st.rt[i] = `RRPC_MOM_HOLD_MS;
        next_st.act[i] = 1'b1;
        if (!st.act[i] && !mom[i])
          next_st.rly[i] = !st.rly[i];
      end
      if (mom[i])
        next_st.rly[i] = next_st.act[i];
    end
    // Drive high energises the coil: common moves to NO
    next_st.rly = next_st.rly & en;
    // Relay chatter doubles as the buzzer on mains units
    if (mains && fb_state)
      next_st.rly = fb_on ? 4'(1 << st.sel) : 4'h0;
    if (mains && !sup)
    begin
      next_st.rly = 4'h0;
      next_st.act = 4'h0;
      next_st.rt = '0;
    end

    next_st.buz = mains && fb_on;
    next_st.led = !mains && (fb_on || st.fsm == RRPC_CAPT
                  || (btn && st.hold >= `RRPC_HOLD_LED_MS
                      && st.hold < `RRPC_ERASE_MS));
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '0;
      st.fsm <= RRPC_BOOT;
      st.tmr <= `RRPC_BOOT_MS;
      st.ctrl <= `RRPC_CTRL_RST;
    end
    else if (pclken)
      st <= next_st;
  end

  assign prdata = st.prdata;
  assign pslverr = st.pslverr;
  assign pready = pclken;
  assign relay_outputs_all = st.rly;
  assign learn_led = st.led;
  assign buzzer = st.buz;

  default clocking tcb @(posedge pclk iff pclken);
  endclocking
  default disable iff (!presetn);

  sequence s_second_code;
    st.fsm == RRPC_CAPT && new_press && !fb_busy && rx.code == st.cap;
  endsequence
  sequence s_hold_done;
    !mains && btn && st.tick && st.hold == `RRPC_ERASE_MS - 14'd1;
  endsequence

  a_first_select: assert property (
    st.fsm == RRPC_NORMAL && press |=> st.fsm == RRPC_SELECT
    && st.sel == 2'd0 && st.fb_n == 8'd2)
    else $error("first press did not pick relay one");
  a_sel_advance: assert property (
    st.fsm == RRPC_SELECT && press && !fb_busy
    |=> st.sel == $past(sel_nx))
    else $error("press did not advance relay");
  a_led_steady: assert property (
    !mains && st.fsm == RRPC_CAPT && $past(st.fsm) == RRPC_CAPT
    |-> learn_led)
    else $error("learn led not steady");
  a_store_done: assert property (
    s_second_code |=> st.store && st.fsm == RRPC_DONE)
    else $error("second code not stored");
  a_hold_erase: assert property (
    s_hold_done |=> st.erase ##1 !learn_led)
    else $error("long hold did not erase");
  a_count_four: assert property (
    eval && st.pc_n == `RRPC_PC_LEARN1 |=> st.fsm == RRPC_SELECT
    && st.sel == 2'd0 && st.fb_n == 8'd2)
    else $error("four cycles did not start learn one");
  a_count_six: assert property (
    eval && st.pc_n == `RRPC_PC_LEARN2 |=> st.fsm == RRPC_SELECT
    && st.sel == 2'd1 && st.fb_n == 8'd4)
    else $error("six cycles did not start learn two");
  a_count_ten: assert property (
    eval && st.pc_n == `RRPC_PC_ERASE |=> st.fsm == RRPC_CLICK)
    else $error("ten cycles did not start clicking");
  a_two_relay: assert property (
    two && $past(two) |-> relay_outputs_all[3:2] == 2'b00)
    else $error("unused relays driven");
  a_mom_operate: assert property (
    st.fsm == RRPC_NORMAL && hit[0] && mom[0] && (sup || !mains)
    |=> relay_outputs_all[0])
    else $error("momentary relay not operated");
  a_latch_toggle: assert property (
    st.fsm == RRPC_NORMAL && hit[0] && !st.act[0] && !mom[0]
    && (sup || !mains)
    |=> relay_outputs_all[0] != $past(relay_outputs_all[0]))
    else $error("latching relay did not toggle");
endmodule : rrpc_top

// File: tb/rrpc_top_tb.sv
// Bench for the pairing controller: APB rows, learn, relay modes, erase
// Assumes rrpc_top with a shortened tick and a transmitter model beside it
`timescale 1ns/10ps
module rrpc_top_tb;
  import rrpc_pkg::*;
  localparam int MS = 2;
  typedef struct {
    logic        wr;
    logic [11:0] a;
    logic [31:0] d;
    logic        err;
  } rrpc_row_t;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  rrpc_rx_t    rx;
  logic        btn = 1'b0;
  logic        jpa = 1'b0;
  logic        jpb = 1'b0;
  logic        sup = 1'b1;
  logic [3:0]  rly;
  logic        led;
  logic        buzzer;
  logic [31:0] rd;
  logic        er;
  logic [3:0]  held;
  int          fail_count = 0;
  int          comparisons = 0;
  int          cycles = 0;
  localparam int M = 32'h0003_F037;
  rrpc_row_t rows [8] = '{
    '{1'b1, 12'h000, 32'h0000_0002, 1'b0}, '{1'b0, 12'h000, 32'h0000_0002, 1'b0},
    '{1'b1, 12'h000, 32'h0000_0000, 1'b0}, '{1'b0, 12'h004, 32'h0000_0001, 1'b0},
    '{1'b0, 12'h008, 32'h0000_0000, 1'b0}, '{1'b0, 12'h00C, 32'h0000_0000, 1'b1},
    '{1'b1, 12'h004, 32'hFFFF_FFFF, 1'b0}, '{1'b0, 12'h004, 32'h0000_0001, 1'b0}};

  always #5 pclk = ~pclk;

  rrpc_top #(.MS_CYCLES(MS)) i_dut (.pclk(pclk), .presetn(presetn),
    .pclken(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx(rx), .learn_pushbutton(btn),
    .mode_jumper_a(jpa), .mode_jumper_b(jpb), .supply_sense(sup),
    .relay_outputs_all(rly), .learn_led(led), .buzzer(buzzer));
  rrpc_tx_model i_tx (.pclk(pclk), .rx(rx));

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  task automatic check(input string w, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", w, e, g);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n * MS) @(posedge pclk);
  endtask : tick
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic sts(input string w, input logic [31:0] e);
    apb(1'b0, 12'h004, 32'h0000_0000);
    check(w, e, rd & M);
  endtask : sts
  task automatic push(input int n);
    btn <= 1'b1;
    tick(n);
    btn <= 1'b0;
    tick(5);
  endtask : push
  task automatic frame(input logic [27:0] c, input logic [3:0] e);
    i_tx.send(c);
    repeat (3) @(posedge pclk);
    #1 check("relays", {28'h0, e}, {28'h0, rly});
  endtask : frame
  // Mid-run reset, then n roughly one-second power cycles on mains
  task automatic pc_learn(input int n, input logic [3:0] r,
                          input logic [31:0] s);
    presetn <= 1'b0;
    tick(2);
    presetn <= 1'b1;
    tick(2);
    sts("after reset", 32'h0000_0001);
    apb(1'b1, 12'h000, 32'h0000_0001);
    repeat (n)
    begin
      sup <= 1'b0;
      tick(500);
      sup <= 1'b1;
      tick(500);
    end
    tick(4600);
    check("buzz", 32'h1, {31'h0, buzzer});
    check("chatter", {28'h0, r}, {28'h0, rly});
    sts("pc learn", s);
    tick(200);
    check("buzz gap", 32'h0, {31'h0, buzzer});
  endtask : pc_learn

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 95000)
    begin
      fail_count++;
      $display("Error timeout expected end seen hang");
      complete_run();
    end
  end

  initial
  begin
    repeat (20) @(posedge pclk);
    check("outputs in reset", 32'h0, {26'h0, rly, led, buzzer});
    presetn <= 1'b1;
    tick(2);
    foreach (rows[i])
    begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      check("pslverr", {31'h0, rows[i].err}, {31'h0, er});
      if (!rows[i].wr)
        check("read data", rows[i].d, rd);
    end
    $display("Test registers done");
    push(40);
    tick(100);
    check("select flash", 32'h1, {31'h0, led});
    push(40);
    sts("press in flash", 32'h0000_0002);
    tick(600);
    push(40);
    sts("advance", 32'h0000_0012);
    tick(1100);
    frame(28'h123_4567, 4'h0);
    check("steady led", 32'h1, {31'h0, led});
    sts("capture", 32'h0000_0013);
    tick(300);
    frame(28'h123_4567, 4'h0);
    tick(1700);
    sts("stored", 32'h0000_1011);
    $display("Test learn done");
    frame(28'h123_4567, 4'h2);
    tick(300);
    frame(28'h123_4567, 4'h0);
    tick(300);
    frame(28'h765_4321, 4'h0);
    jpa <= 1'b1;
    tick(2);
    frame(28'h123_4567, 4'h2);
    tick(100);
    frame(28'h123_4567, 4'h2);
    tick(200);
    check("held", 32'h2, {28'h0, rly});
    tick(100);
    check("released", 32'h0, {28'h0, rly});
    jpa <= 1'b0;
    jpb <= 1'b1;
    tick(2);
    frame(28'h123_4567, 4'h2);
    tick(300);
    check("latched", 32'h2, {28'h0, rly});
    $display("Test relay modes done");
    push(10050);
    check("led off", 32'h0, {31'h0, led});
    sts("erased", 32'h0000_0011);
    held = 4'h2;
    tick(300);
    frame(28'h123_4567, held);
    $display("Test erase done");
    pc_learn(4, 4'h1, 32'h0000_0002);
    pc_learn(6, 4'h2, 32'h0000_0012);
    $display("Test power cycles done");
    complete_run();
  end
endmodule : rrpc_top_tb

// File: tb/rrpc_tx_model.sv
// Transmitter model: one decoded frame per send, scrambled code when idle
// Assumes frames are taken on the rising edge of pclk
`timescale 1ns/10ps
`include "rrpc_defs.svh"
module rrpc_tx_model (
  input  wire logic         pclk,
  output rrpc_pkg::rrpc_rx_t rx
);
  import rrpc_pkg::*;
  initial
  begin
    rx = '0;
  end
  // Idle code is inverted so a stale value never looks like a match
  task automatic send(input logic [`RRPC_CODE_W-1:0] code);
    @(posedge pclk);
    rx <= '{valid: 1'b1, code: code};
    @(posedge pclk);
    rx <= '{valid: 1'b0, code: ~code};
  endtask : send
endmodule : rrpc_tx_model
